// ===== core/ais_scaler.v
// Purpose: analog input scaling to user units, parameter entries
// Assumes: entry port addressed by object index and subindex
// Notes:   reading = (raw + offset) * numerator / denominator
//
// Overview of operation
// R1: add signed offset to raw count first
// R2: multiply corrected value by signed numerator
// R3: divide product by signed denominator
// R4: default parameters give raw converter digits
// R5: voltage mode: count times 10 V / 1023
// R6: current mode: count times 20 mA / 1023
// R7: reading is live signed 32-bit, read-only
// R8: subindex zero reads number of inputs
// R9: second slot only when second input fitted
// R10: offset is signed 16-bit read/write
// R11: numerator signed 16-bit, reset to one
// R12: full-width product, truncate, hold on zero divisor
`timescale 1ns/1ps
`include "ais_defines.vh"
module ais_scaler #(
   parameter NUM_INPUTS = 1,
   parameter ADC_W      = 10
) (
   input  wire             clk_i,
   input  wire             nrst_i,
   input  wire [ADC_W-1:0] adc1_i,
   input  wire [ADC_W-1:0] adc2_i,
   input  wire             wr_i,
   input  wire             rd_i,
   input  wire [15:0]      index_i,
   input  wire [7:0]       sub_i,
   input  wire [31:0]      wdata_i,
   output reg  [31:0]      rdata_o,
   output reg              ack_o,
   output reg              err_o,
   output reg  [31:0]      reading1_o,
   output reg  [31:0]      reading2_o,
   output reg  [31:0]      eng1_o,
   output reg  [31:0]      eng2_o
);
   localparam W = 34;
   // ****************************************************************
   // parameter entries
   // ****************************************************************
   reg [15:0] off_q [0:1];
   reg [15:0] num_q [0:1];
   reg [15:0] den_q [0:1];
   reg [ADC_W-1:0] s1a_q;
   reg [ADC_W-1:0] s1b_q;
   reg [ADC_W-1:0] s2a_q;
   reg [ADC_W-1:0] s2b_q;
   reg             sel_q;
   reg             run_q;
   reg             start_q;
   reg [W-1:0]     prod_q;
   reg [W-1:0]     dden_q;
   reg [31:0]      read_q [0:1];
   wire            busy;
   wire            done;
   wire [W-1:0]    quo;
   integer         i;

   function slot_ok;
      input [7:0] s;
      begin
         slot_ok = (s == `AIS_SUB_FIRST) ||
                   (s == `AIS_SUB_SECOND && NUM_INPUTS > 1); // [R9]
      end
   endfunction

   function [31:0] sx16;
      input [15:0] v;
      begin
         sx16 = {{16{v[15]}}, v};
      end
   endfunction

   wire       sub_hi = (sub_i == `AIS_SUB_SECOND);
   wire       idx_rw = (index_i == `AIS_IDX_OFFSET) ||
                       (index_i == `AIS_IDX_NUMERATOR) ||
                       (index_i == `AIS_IDX_DENOMINATOR);
   wire       idx_ok = idx_rw || (index_i == `AIS_IDX_READING);

   // ****************************************************************
   // converter input synchronisers
   // ****************************************************************
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1a_q <= {ADC_W{1'b0}};
         s1b_q <= {ADC_W{1'b0}};
         s2a_q <= {ADC_W{1'b0}};
         s2b_q <= {ADC_W{1'b0}};
      end else begin
         s1a_q <= adc1_i;
         s1b_q <= s1a_q;
         s2a_q <= adc2_i;
         s2b_q <= s2a_q;
      end
   end

   // ****************************************************************
   // arithmetic front end
   // ****************************************************************
   wire [ADC_W-1:0] raw_sel = sel_q ? s2b_q : s1b_q;
   wire [17:0] corr = $signed({1'b0, raw_sel}) +
                      $signed({{2{off_q[sel_q][15]}}, off_q[sel_q]}); // [R1]
   wire signed [W-1:0] prod_full = $signed(corr) *
                                   $signed(num_q[sel_q]); // [R2] [R12]

   ais_divider #(.W(W)) u_div (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .start_i (start_q),
      .num_i   (prod_q),
      .den_i   (dden_q),
      .busy_o  (busy),
      .done_o  (done),
      .quo_o   (quo)
   );

   // ****************************************************************
   // conversion sequencer
   // ****************************************************************
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_q   <= 1'b0;
         run_q   <= 1'b0;
         start_q <= 1'b0;
         prod_q  <= {W{1'b0}};
         dden_q  <= {W{1'b0}};
         read_q[0] <= `AIS_RST_READING;
         read_q[1] <= `AIS_RST_READING;
      end else begin
         start_q <= 1'b0;
         if (!run_q) begin
            prod_q  <= prod_full;
            dden_q  <= {{(W-16){den_q[sel_q][15]}}, den_q[sel_q]};
            if (den_q[sel_q] != 16'h0000) begin // [R12]
               run_q   <= 1'b1;
               start_q <= 1'b1;
            end else if (NUM_INPUTS > 1) begin
               sel_q <= ~sel_q;
            end
         end else if (done) begin
            read_q[sel_q] <= quo[31:0]; // [R3] [R4] [R7]
            run_q <= 1'b0;
            if (NUM_INPUTS > 1)
               sel_q <= ~sel_q;
         end
      end
   end

   // ****************************************************************
   // parameter entry access
   // ****************************************************************
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (i = 0; i < 2; i = i + 1) begin
            off_q[i] <= `AIS_RST_OFFSET;
            num_q[i] <= `AIS_RST_NUMERATOR; // [R11]
            den_q[i] <= `AIS_RST_DENOMINATOR;
         end
         rdata_o <= 32'h00000000;
         ack_o   <= 1'b0;
         err_o   <= 1'b0;
      end else begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         if (wr_i) begin
            if (idx_rw && slot_ok(sub_i)) begin
               ack_o <= 1'b1;
               case (index_i)
                  `AIS_IDX_OFFSET:    off_q[sub_hi] <= wdata_i[15:0]; // [R10]
                  `AIS_IDX_NUMERATOR: num_q[sub_hi] <= wdata_i[15:0]; // [R11]
                  default:            den_q[sub_hi] <= wdata_i[15:0];
               endcase
            end else begin
               err_o <= 1'b1; // reading and count entries are read-only
            end
         end else if (rd_i) begin
            if (idx_ok && sub_i == `AIS_SUB_COUNT) begin
               ack_o   <= 1'b1;
               rdata_o <= NUM_INPUTS; // [R8]
            end else if (idx_ok && slot_ok(sub_i)) begin
               ack_o <= 1'b1;
               case (index_i)
                  `AIS_IDX_READING:   rdata_o <= read_q[sub_hi]; // [R7]
                  `AIS_IDX_OFFSET:    rdata_o <= sx16(off_q[sub_hi]); // [R10]
                  `AIS_IDX_NUMERATOR: rdata_o <= sx16(num_q[sub_hi]);
                  default:            rdata_o <= sx16(den_q[sub_hi]);
               endcase
            end else begin
               err_o <= 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // published readings and engineering views
   // ****************************************************************
   function [31:0] eng;
      input [ADC_W-1:0] raw;
      input             cur;
      reg   [41:0]      p;
      reg   [41:0]      q;
      begin
         p = raw * (cur ? `AIS_CURR_FULL_UA : `AIS_VOLT_FULL_MV);
         q = p / `AIS_ADC_FULL_SCALE;
         eng = q[31:0];
      end
   endfunction

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reading1_o <= `AIS_RST_READING;
         reading2_o <= `AIS_RST_READING;
         eng1_o     <= 32'h00000000;
         eng2_o     <= 32'h00000000;
      end else begin
         reading1_o <= read_q[0]; // [R7]
         reading2_o <= (NUM_INPUTS > 1) ? read_q[1] : 32'h00000000; // [R9]
         eng1_o     <= eng(s1b_q, 1'b0); // [R5]
         eng2_o     <= eng(s2b_q, 1'b1); // [R6]
      end
   end
endmodule // ais_scaler

// ===== inc/ais_defines.vh
// Purpose: constants for the analog input scaling block
// Assumes: object index and subindex addressing of parameter entries
// Notes:   offsets are object indices, subindex selects the input slot
`ifndef AIS_DEFINES_VH
`define AIS_DEFINES_VH
// ****************************************************************
// object indices
// ****************************************************************
`define AIS_IDX_READING     16'h3320
`define AIS_IDX_OFFSET      16'h3321
`define AIS_IDX_NUMERATOR   16'h3322
`define AIS_IDX_DENOMINATOR 16'h3323
// ****************************************************************
// subindices and reset values
// ****************************************************************
`define AIS_SUB_COUNT       8'h00
`define AIS_SUB_FIRST       8'h01
`define AIS_SUB_SECOND      8'h02
`define AIS_RST_READING     32'h00000000
`define AIS_RST_OFFSET      16'h0000
`define AIS_RST_NUMERATOR   16'h0001
`define AIS_RST_DENOMINATOR 16'h0001
// ****************************************************************
// converter full scale, unit figures and divider cycle count
// ****************************************************************
`define AIS_ADC_FULL_SCALE  10'h3FF
`define AIS_VOLT_FULL_MV    32'h00002710
`define AIS_CURR_FULL_UA    32'h00004E20
`define AIS_DIV_CYCLES      6'h22
`endif

// ===== core/ais_divider.v
// Purpose: signed restoring divider, quotient truncated toward zero
// Assumes: divisor not zero when started
// Notes:   one quotient bit per clock
`timescale 1ns/1ps
module ais_divider #(
   parameter W = 34
) (
   input  wire         clk_i,
   input  wire         nrst_i,
   input  wire         start_i,
   input  wire [W-1:0] num_i,
   input  wire [W-1:0] den_i,
   output reg          busy_o,
   output reg          done_o,
   output reg  [W-1:0] quo_o
);
   reg [W-1:0]  rem_q;
   reg [W-1:0]  quo_q;
   reg [W-1:0]  dvs_q;
   reg          neg_q;
   reg [7:0]    cnt_q;
   wire [W:0]   trial = {rem_q, quo_q[W-1]} - {1'b0, dvs_q};

   function [W-1:0] mag;
      input [W-1:0] v;
      begin
         mag = v[W-1] ? (~v + 1'b1) : v;
      end
   endfunction

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rem_q  <= {W{1'b0}};
         quo_q  <= {W{1'b0}};
         dvs_q  <= {W{1'b0}};
         neg_q  <= 1'b0;
         cnt_q  <= 8'h00;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         quo_o  <= {W{1'b0}};
      end else begin
         done_o <= 1'b0;
         if (start_i && !busy_o) begin
            rem_q  <= {W{1'b0}};
            quo_q  <= mag(num_i);
            dvs_q  <= mag(den_i);
            neg_q  <= num_i[W-1] ^ den_i[W-1];
            cnt_q  <= W[7:0];
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (!trial[W]) begin
               rem_q <= trial[W-1:0];
               quo_q <= {quo_q[W-2:0], 1'b1};
            end else begin
               rem_q <= {rem_q[W-2:0], quo_q[W-1]};
               quo_q <= {quo_q[W-2:0], 1'b0};
            end
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               quo_o  <= neg_q ? ~{quo_q[W-2:0], ~trial[W]} + 1'b1
                               : {quo_q[W-2:0], ~trial[W]};
            end
         end
      end
   end
endmodule // ais_divider

// ===== tb/ais_adc_model.sv
// Purpose: converter model feeding raw counts
// Assumes: levels set by the bench between edges
// Notes:   one clock of conversion latency
`timescale 1ns/1ps
module ais_adc_model (
   input  wire       clk_i,
   input  wire [9:0] level1_i,
   input  wire [9:0] level2_i,
   output reg  [9:0] adc1_o,
   output reg  [9:0] adc2_o
);
   initial begin
      adc1_o = 10'h000;
      adc2_o = 10'h000;
   end
   always @(posedge clk_i) begin
      adc1_o <= level1_i;
      adc2_o <= level2_i;
   end
endmodule // ais_adc_model

// ===== tb/ais_scaler_assertions.sv
// Purpose: port checker for the scaler
// Assumes: one clock, async active-low reset
// Notes:   bound into ais_scaler
`timescale 1ns/1ps
module ais_scaler_chk #(
   parameter NUM_INPUTS = 1,
   parameter ADC_W      = 10
) (
   input wire             clk_i,
   input wire             nrst_i,
   input wire [ADC_W-1:0] adc1_i,
   input wire [ADC_W-1:0] adc2_i,
   input wire             wr_i,
   input wire             rd_i,
   input wire [15:0]      index_i,
   input wire [7:0]       sub_i,
   input wire [31:0]      wdata_i,
   input wire [31:0]      rdata_o,
   input wire             ack_o,
   input wire             err_o,
   input wire [31:0]      reading1_o,
   input wire [31:0]      reading2_o,
   input wire [31:0]      eng1_o,
   input wire [31:0]      eng2_o
);
   // ****
   // access answers and output bounds
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_req;
      wr_i || rd_i;
   endsequence
   sequence s_ro_wr;
      wr_i && index_i == 16'h3320;
   endsequence
   sequence s_cnt_rd;
      rd_i && !wr_i && sub_i == 8'h00 && index_i[15:2] == 14'h0CC8;
   endsequence
   sequence s_cnt_ans;
      ack_o && rdata_o == NUM_INPUTS;
   endsequence
   sequence s_slot2;
      (wr_i || rd_i) && sub_i == 8'h02 && NUM_INPUTS == 1;
   endsequence
   one_answer_a: assert property (s_req |=> ack_o != err_o)
      else $error("access not answered once");
   quiet_bus_a: assert property (!(wr_i || rd_i) |=> !ack_o && !err_o)
      else $error("answer without access");
   ro_reading_a: assert property (s_ro_wr |=> err_o && !ack_o)
      else $error("reading entry accepted a write");
   count_value_a: assert property (s_cnt_rd |=> s_cnt_ans)
      else $error("wrong input count");
   count_ro_a: assert property (wr_i && sub_i == 8'h00 |=> err_o)
      else $error("count entry accepted a write");
   slot_two_a: assert property (s_slot2 |=> err_o)
      else $error("absent slot accepted");
   spare_zero_a: assert property (NUM_INPUTS > 1 || reading2_o == 0)
      else $error("absent slot reading not zero");
   sub_range_a: assert property (s_req ##0 sub_i > 8'h02 |=> err_o)
      else $error("subindex out of range accepted");
   rdata_keep_a: assert property (!rd_i || wr_i |=> $stable(rdata_o))
      else $error("read data moved without a read");
   volt_range_a: assert property (eng1_o <= 32'h00002710)
      else $error("voltage above full scale");
endmodule // ais_scaler_chk
bind ais_scaler ais_scaler_chk #(.NUM_INPUTS(NUM_INPUTS), .ADC_W(ADC_W)) u_chk (
   .clk_i(clk_i), .nrst_i(nrst_i), .adc1_i(adc1_i), .adc2_i(adc2_i),
   .wr_i(wr_i), .rd_i(rd_i), .index_i(index_i), .sub_i(sub_i),
   .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o), .err_o(err_o),
   .reading1_o(reading1_o), .reading2_o(reading2_o), .eng1_o(eng1_o),
   .eng2_o(eng2_o));

// ===== tb/tb.sv
// Purpose: self-checking bench for the scaler
// Assumes: one input fitted, seed 80
// Notes:   reading compared SETTLE cycles after a change
`timescale 1ns/1ps
module tb;
   reg         clk_i   = 1'b0;
   reg         nrst_i  = 1'b0;
   reg         wr_i    = 1'b0;
   reg         rd_i    = 1'b0;
   reg  [15:0] index_i = 16'h0000;
   reg  [7:0]  sub_i   = 8'h00;
   reg  [31:0] wdata_i = 32'h00000000;
   reg  [9:0]  lvl1    = 10'h000;
   reg  [9:0]  lvl2    = 10'h000;
   wire [9:0]  adc1_i, adc2_i;
   wire [31:0] rdata_o, reading1_o, reading2_o, eng1_o, eng2_o;
   wire        ack_o, err_o;
   integer     failures = 0, n_tests = 0, i;
   // two full conversion rounds plus converter and sync latency
   localparam integer SETTLE = 80;
   reg  [31:0] rd_v, off, num, den, exp_r;
   always #5 clk_i = ~clk_i;
   ais_adc_model u_ais_adc_model (.clk_i(clk_i), .level1_i(lvl1),
      .level2_i(lvl2), .adc1_o(adc1_i), .adc2_o(adc2_i));
   ais_scaler u_ais_scaler (.clk_i(clk_i), .nrst_i(nrst_i), .adc1_i(adc1_i),
      .adc2_i(adc2_i), .wr_i(wr_i), .rd_i(rd_i), .index_i(index_i),
      .sub_i(sub_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o),
      .err_o(err_o), .reading1_o(reading1_o), .reading2_o(reading2_o),
      .eng1_o(eng1_o), .eng2_o(eng2_o));
   // ****
   // tasks
   // ****
   task report_and_stop;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task acc(input w, input [15:0] idx, input [7:0] sb, input [31:0] d,
            input bad);
      @(negedge clk_i);
      wr_i = w; rd_i = !w; index_i = idx; sub_i = sb; wdata_i = d;
      @(negedge clk_i);
      wr_i = 1'b0; rd_i = 1'b0; index_i = ~idx; wdata_i = ~d;
      chk({ack_o, err_o}, bad ? 32'h1 : 32'h2);
      rd_v = rdata_o;
   endtask
   function [31:0] expect_rd(input [31:0] r, o, n, d);
      longint p;
      p = (longint'(r) + longint'($signed(o[15:0])))
          * longint'($signed(n[15:0]));
      return p / longint'($signed(d[15:0]));
   endfunction
   // ****
   // sequence
   // ****
   initial begin
      #200000;
      failures = failures + 1;
      report_and_stop;
   end
   initial begin
      i = $urandom(80);
      repeat (20) @(negedge clk_i);
      nrst_i = 1'b1;
      lvl1 = 10'h3FF;
      repeat (SETTLE) @(negedge clk_i);
      chk(reading1_o, 32'h3FF);
      chk(eng1_o, 32'h2710);
      for (i = 0; i < 4; i = i + 1) begin
         acc(1'b0, 16'h3320 + i, 8'h00, 0, 1'b0);
         chk(rd_v, 32'h1);
      end
      acc(1'b0, 16'h3322, 8'h01, 0, 1'b0);
      chk(rd_v, 32'h1);
      acc(1'b1, 16'h3320, 8'h01, 5, 1'b1);
      acc(1'b1, 16'h3321, 8'h00, 5, 1'b1);
      acc(1'b1, 16'h3321, 8'h02, 5, 1'b1);
      acc(1'b0, 16'h3322, 8'h03, 0, 1'b1);
      acc(1'b0, 16'h3324, 8'h01, 0, 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
         lvl1 = $urandom;
         lvl2 = $urandom;
         off = (i == 0) ? 32'hFFFF : $urandom;
         num = (i == 0) ? 32'h8000 : $urandom;
         den = (i == 1) ? 32'hFFFF : $urandom;
         if (den[15:0] == 16'h0000) den = 32'h3;
         acc(1'b1, 16'h3321, 8'h01, off, 1'b0);
         acc(1'b1, 16'h3322, 8'h01, num, 1'b0);
         acc(1'b1, 16'h3323, 8'h01, den, 1'b0);
         acc(1'b0, 16'h3321, 8'h01, 0, 1'b0);
         chk(rd_v, {{16{off[15]}}, off[15:0]});
         repeat (SETTLE) @(negedge clk_i);
         exp_r = expect_rd({22'h0, lvl1}, off, num, den);
         chk(reading1_o, exp_r);
         chk(reading2_o, 32'h0);
         chk(eng1_o, {22'h0, lvl1} * 32'd10000 / 32'd1023);
         chk(eng2_o, {22'h0, lvl2} * 32'd20000 / 32'd1023);
         acc(1'b0, 16'h3320, 8'h01, 0, 1'b0);
         chk(rd_v, exp_r);
      end
      acc(1'b1, 16'h3323, 8'h01, 0, 1'b0);
      lvl1 = ~lvl1;
      repeat (SETTLE) @(negedge clk_i);
      chk(reading1_o, exp_r);
      // mid-run reset must clear the reading and restore the numerator and offset defaults
      nrst_i = 1'b0;
      @(negedge clk_i);
      chk(reading1_o, 32'h0);
      nrst_i = 1'b1;
      acc(1'b0, 16'h3322, 8'h01, 0, 1'b0);
      chk(rd_v, 32'h1);
      acc(1'b0, 16'h3321, 8'h01, 0, 1'b0);
      chk(rd_v, 32'h0);
      report_and_stop;
   end
endmodule // tb
